// ---- verilog/mrsa_pkg.sv ----
// Package with the constants, operation codes and carriers of the rotate, subtract and skip ALU.
package mrsa_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int MRSA_DATA_W = 8;
  localparam int MRSA_MEM_AW = 9;
  localparam int MRSA_BUS_AW = 10;
  localparam int MRSA_PROG_AW = 13;
  localparam int MRSA_PROG_W = 16;
  localparam int MRSA_PTR_W = 8;
  localparam int MRSA_PAGE_W = MRSA_PROG_AW - MRSA_PTR_W;
  localparam int MRSA_DMEM_DEPTH = 352;

  // ----------------------------------------------------------------------
  // Register offsets on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [MRSA_BUS_AW-1:0] MRSA_ACC_OFFSET = 10'h000;
  localparam logic [MRSA_BUS_AW-1:0] MRSA_STATUS_OFFSET = 10'h004;
  localparam logic [MRSA_BUS_AW-1:0] MRSA_PTR_OFFSET = 10'h008;
  localparam logic [MRSA_BUS_AW-1:0] MRSA_HIGH_OFFSET = 10'h00C;
  localparam logic [MRSA_BUS_AW-1:0] MRSA_STATE_OFFSET = 10'h010;
  localparam logic [MRSA_BUS_AW-1:0] MRSA_DMEM_BASE = 10'h200;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int MRSA_CARRY_BIT = 0;
  localparam int MRSA_HALF_BIT = 1;
  localparam int MRSA_ZERO_BIT = 2;
  localparam int MRSA_RANGE_BIT = 3;
  localparam int MRSA_BUSY_BIT = 0;
  localparam int MRSA_SKIP_BIT = 1;
  localparam logic [7:0] MRSA_ACC_RESET = 8'h00;
  localparam logic [7:0] MRSA_PTR_RESET = 8'h00;
  localparam logic [7:0] MRSA_HIGH_RESET = 8'h00;
  localparam logic [7:0] MRSA_ALL_ONES = 8'hFF;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    MRSA_NOP,
    MRSA_ROTATE_LEFT_VIA_CARRY,
    MRSA_ROTATE_RIGHT_IN_PLACE,
    MRSA_ROTATE_RIGHT_VIA_CARRY,
    MRSA_MINUS_WITH_BORROW,
    MRSA_MINUS,
    MRSA_SKIP_AFTER_DECREMENT,
    MRSA_SKIP_AFTER_INCREMENT,
    MRSA_SKIP_IF_BIT_ONE,
    MRSA_SKIP_IF_BIT_ZERO,
    MRSA_SKIP_IF_BYTE_ZERO,
    MRSA_SKIP_IF_ZERO_WITH_LOAD,
    MRSA_SET_BYTE,
    MRSA_SET_BIT,
    MRSA_NIBBLE_EXCHANGE,
    MRSA_TABLE_READ_CURRENT_PAGE,
    MRSA_TABLE_READ_LAST_PAGE,
    MRSA_EXCLUSIVE_OR
  } mrsa_op_e;

  typedef struct packed {
    mrsa_op_e op;
    logic to_acc;
    logic use_imm;
    logic [MRSA_DATA_W-1:0] imm;
    logic [2:0] bit_sel;
    logic [MRSA_MEM_AW-1:0] mem_addr;
    logic [MRSA_PAGE_W-1:0] code_page;
  } mrsa_cmd_s;

  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } mrsa_flags_s;

endpackage : mrsa_pkg

// ---- verilog/mrsa_alu.sv ----
// Combinational result, flag and skip logic for one operation.
`timescale 1ns/1ps
module mrsa_alu (
  input wire mrsa_pkg::mrsa_cmd_s cmd,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire mrsa_pkg::mrsa_flags_s flags,
  output logic [7:0] result,
  output logic wr_acc,
  output logic wr_mem,
  output mrsa_pkg::mrsa_flags_s flags_next,
  output logic is_skip,
  output logic skip_cond
);
  import mrsa_pkg::*;

  logic [7:0] operand;
  logic borrow;
  logic [8:0] full_diff;
  logic [4:0] half_diff;
  logic upd_zero;

  assign operand = cmd.use_imm ? cmd.imm : mem;
  assign borrow = (cmd.op == MRSA_MINUS_WITH_BORROW) ? ~flags.carry_flag : 1'b0;
  assign full_diff = {1'b0, acc} - {1'b0, operand} - {8'h00, borrow};
  assign half_diff = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, borrow};

  always_comb begin
    result = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    flags_next = flags;
    is_skip = 1'b0;
    skip_cond = 1'b0;
    upd_zero = 1'b0;
    case (cmd.op)
      MRSA_ROTATE_LEFT_VIA_CARRY: begin
        result = {mem[6:0], flags.carry_flag};
        flags_next.carry_flag = mem[7];
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_ROTATE_RIGHT_IN_PLACE: begin
        result = {mem[0], mem[7:1]};
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_ROTATE_RIGHT_VIA_CARRY: begin
        result = {flags.carry_flag, mem[7:1]};
        flags_next.carry_flag = mem[0];
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_MINUS_WITH_BORROW, MRSA_MINUS: begin
        result = full_diff[7:0];
        flags_next.carry_flag = ~full_diff[8];
        flags_next.half_carry_flag = ~half_diff[4];
        flags_next.signed_range_flag = (acc[7] ^ operand[7]) & (acc[7] ^ full_diff[7]);
        upd_zero = 1'b1;
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_SKIP_AFTER_DECREMENT: begin
        result = mem - 8'h01;
        is_skip = 1'b1;
        skip_cond = (result == 8'h00);
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_SKIP_AFTER_INCREMENT: begin
        result = mem + 8'h01;
        is_skip = 1'b1;
        skip_cond = (result == 8'h00);
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_SKIP_IF_BIT_ONE: begin
        is_skip = 1'b1;
        skip_cond = mem[cmd.bit_sel];
      end
      MRSA_SKIP_IF_BIT_ZERO: begin
        is_skip = 1'b1;
        skip_cond = ~mem[cmd.bit_sel];
      end
      MRSA_SKIP_IF_BYTE_ZERO: begin
        is_skip = 1'b1;
        skip_cond = (mem == 8'h00);
      end
      MRSA_SKIP_IF_ZERO_WITH_LOAD: begin
        result = mem;
        wr_acc = 1'b1;
        is_skip = 1'b1;
        skip_cond = (mem == 8'h00);
      end
      MRSA_SET_BYTE: begin
        result = MRSA_ALL_ONES;
        wr_mem = 1'b1;
      end
      MRSA_SET_BIT: begin
        result = mem | (8'h01 << cmd.bit_sel);
        wr_mem = 1'b1;
      end
      MRSA_NIBBLE_EXCHANGE: begin
        result = {mem[3:0], mem[7:4]};
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      MRSA_EXCLUSIVE_OR: begin
        result = acc ^ operand;
        upd_zero = 1'b1;
        wr_acc = cmd.to_acc;
        wr_mem = ~cmd.to_acc;
      end
      default: begin
        result = 8'h00;
      end
    endcase
    if (upd_zero) begin
      flags_next.zero_flag = (result == 8'h00);
    end
  end

endmodule : mrsa_alu

// ---- verilog/mrsa_core.sv ----
// Execution datapath for rotates, subtracts, skips, table reads and XOR, with its register port.
// Notes on behaviour
// - Rotate left via carry: old carry into bit 0, bit 7 into carry, memory destination.
// - Accumulator form of rotate left via carry writes accumulator, keeps memory.
// - Plain rotate right wraps bit 0 into bit 7, no flags touched.
// - Rotate right via carry: carry into bit 7, bit 0 into carry.
// - Subtract with borrow: accumulator minus operand minus inverted carry, flags updated.
// - Memory form of subtract with borrow writes the difference to memory.
// - Subtraction carry is 0 for a negative difference, 1 otherwise.
// - Plain subtract takes memory or immediate, either destination, same four flags.
// - Decrement and skip when the result is zero.
// - Increment and skip when the result is zero.
// - Skip operations take two machine cycles and change no flag.
// - Skip when the selected bit is one.
// - Skip when the selected bit is zero.
// - Skip when the whole byte is zero, nothing modified.
// - Load byte into accumulator and skip when it is zero.
// - Set byte writes all ones; set bit forces one bit, no flags.
// - Nibble exchange swaps the halves, accumulator form writes accumulator only.
// - Table read current page: low byte to memory, high byte to latch.
// - Table read last page does the same from the final code page.
// - Exclusive OR with memory or immediate, either destination, only zero flag.
`timescale 1ns/1ps
module mrsa_core #(
  parameter int DMEM_DEPTH = mrsa_pkg::MRSA_DMEM_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire mrsa_pkg::mrsa_cmd_s cmd,
  output logic busy,
  output logic done,
  output logic skip_next,
  output logic [mrsa_pkg::MRSA_PROG_AW-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [mrsa_pkg::MRSA_PROG_W-1:0] prog_data,
  input wire logic [mrsa_pkg::MRSA_BUS_AW-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata
);
  import mrsa_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DUMMY,
    ST_TABLE_REQ,
    ST_TABLE_WAIT
  } mrsa_state_e;

  // These hold the sequencer state and its command.
  mrsa_state_e state_reg;
  mrsa_cmd_s cmd_reg;

  // These are the architectural registers.
  logic [7:0] acc_reg;
  mrsa_flags_s flags_reg;
  logic [7:0] table_pointer_reg;
  logic [7:0] table_high_latch_reg;
  logic [7:0] dmem [DMEM_DEPTH];

  // These drive the top outputs.
  logic busy_reg;
  logic done_reg;
  logic skip_reg;
  logic last_skip_reg;

  logic [MRSA_PROG_AW-1:0] prog_addr_reg;
  logic prog_rd_reg;
  logic [7:0] rdata_reg;

  // These are decode and ALU results.
  logic [7:0] mem_byte;
  logic [7:0] alu_result;
  logic alu_wr_acc;
  logic alu_wr_mem;
  mrsa_flags_s alu_flags;
  logic alu_is_skip;
  logic alu_skip_cond;

  logic is_table;
  logic exec_now;
  logic exec_wr_acc;
  logic exec_wr_mem;
  logic table_wr;

  logic accept;
  logic bus_in_mem;
  logic [MRSA_BUS_AW-1:0] bus_mem_off;
  logic [MRSA_PAGE_W-1:0] table_page;

  // ----------------------------------------------------------------------
  // Operand fetch and ALU
  // ----------------------------------------------------------------------
  assign mem_byte = (32'(cmd_reg.mem_addr) < DMEM_DEPTH) ? dmem[cmd_reg.mem_addr] : 8'h00;
  assign is_table = (cmd_reg.op == MRSA_TABLE_READ_CURRENT_PAGE) ||
                    (cmd_reg.op == MRSA_TABLE_READ_LAST_PAGE);
  assign accept = cmd_valid && (state_reg == ST_IDLE);
  assign exec_now = (state_reg == ST_EXEC) && !is_table;
  assign exec_wr_acc = exec_now && alu_wr_acc;
  assign exec_wr_mem = exec_now && alu_wr_mem;
  assign table_wr = (state_reg == ST_TABLE_WAIT);

  assign bus_mem_off = bus_addr - MRSA_DMEM_BASE;
  assign bus_in_mem = (bus_addr >= MRSA_DMEM_BASE) && (32'(bus_mem_off) < DMEM_DEPTH);
  assign table_page = (cmd_reg.op == MRSA_TABLE_READ_LAST_PAGE) ?
                      {MRSA_PAGE_W{1'b1}} : cmd_reg.code_page;

  mrsa_alu u_alu (
    .cmd(cmd_reg),
    .acc(acc_reg),
    .mem(mem_byte),
    .flags(flags_reg),
    .result(alu_result),
    .wr_acc(alu_wr_acc),
    .wr_mem(alu_wr_mem),
    .flags_next(alu_flags),
    .is_skip(alu_is_skip),
    .skip_cond(alu_skip_cond)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Skips add a dummy state; table reads add a fetch and a wait state.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (is_table) begin
            state_reg <= ST_TABLE_REQ;
          end else if (alu_is_skip) begin
            state_reg <= ST_DUMMY;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DUMMY: begin
          state_reg <= ST_IDLE;
        end
        ST_TABLE_REQ: begin
          state_reg <= ST_TABLE_WAIT;
        end
        ST_TABLE_WAIT: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= '0;
    end else if (accept) begin
      cmd_reg <= cmd;
    end
  end

  // ----------------------------------------------------------------------
  // Accumulator and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= MRSA_ACC_RESET;
    end else if (exec_wr_acc) begin
      acc_reg <= alu_result;
    end else if (bus_wr && (bus_addr == MRSA_ACC_OFFSET)) begin
      acc_reg <= bus_wdata;
    end
  end

  // Skip, set, swap and table operations hand back the flags unchanged.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= '0;
    end else if (exec_now) begin
      flags_reg <= alu_flags;
    end else if (bus_wr && (bus_addr == MRSA_STATUS_OFFSET)) begin
      flags_reg.carry_flag <= bus_wdata[MRSA_CARRY_BIT];
      flags_reg.half_carry_flag <= bus_wdata[MRSA_HALF_BIT];
      flags_reg.zero_flag <= bus_wdata[MRSA_ZERO_BIT];
      flags_reg.signed_range_flag <= bus_wdata[MRSA_RANGE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Table pointer and high latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      table_pointer_reg <= MRSA_PTR_RESET;
    end else if (bus_wr && (bus_addr == MRSA_PTR_OFFSET)) begin
      table_pointer_reg <= bus_wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      table_high_latch_reg <= MRSA_HIGH_RESET;
    end else if (table_wr) begin
      table_high_latch_reg <= prog_data[15:8];
    end
  end

  // ----------------------------------------------------------------------
  // Program memory port
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prog_addr_reg <= '0;
      prog_rd_reg <= 1'b0;
    end else if ((state_reg == ST_EXEC) && is_table) begin
      prog_addr_reg <= {table_page, table_pointer_reg};
      prog_rd_reg <= 1'b1;
    end else begin
      prog_rd_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------------
  // Instruction writes take the port; a register-port write in the same cycle is dropped.
  // Addresses past the array are ignored.
  always_ff @(posedge clock) begin
    if (exec_wr_mem) begin
      if (32'(cmd_reg.mem_addr) < DMEM_DEPTH) begin
        dmem[cmd_reg.mem_addr] <= alu_result;
      end
    end else if (table_wr) begin
      if (32'(cmd_reg.mem_addr) < DMEM_DEPTH) begin
        dmem[cmd_reg.mem_addr] <= prog_data[7:0];
      end
    end else if (bus_wr && bus_in_mem) begin
      dmem[bus_mem_off[MRSA_MEM_AW-1:0]] <= bus_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Completion outputs
  // ----------------------------------------------------------------------
  // Busy stands from the edge after acceptance until done rises.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
    end else if (accept) begin
      busy_reg <= 1'b1;
    end else if (done_reg || (state_reg == ST_IDLE)) begin
      busy_reg <= 1'b0;
    end else if ((state_reg == ST_EXEC) && !is_table && !alu_is_skip) begin
      busy_reg <= 1'b0;
    end else if ((state_reg == ST_DUMMY) || (state_reg == ST_TABLE_WAIT)) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= ((state_reg == ST_EXEC) && !is_table && !alu_is_skip) ||
                  (state_reg == ST_DUMMY) || (state_reg == ST_TABLE_WAIT);
    end
  end

  // The skip decision is held through the dummy cycle and shown with done.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_skip_reg <= 1'b0;
    end else if (exec_now && alu_is_skip) begin
      last_skip_reg <= alu_skip_cond;
    end else if (accept) begin
      last_skip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= (state_reg == ST_DUMMY) && last_skip_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register port read
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (bus_rd) begin
      if (bus_addr == MRSA_ACC_OFFSET) begin
        rdata_reg <= acc_reg;
      end else if (bus_addr == MRSA_STATUS_OFFSET) begin
        rdata_reg <= 8'h00;
        rdata_reg[MRSA_CARRY_BIT] <= flags_reg.carry_flag;
        rdata_reg[MRSA_HALF_BIT] <= flags_reg.half_carry_flag;
        rdata_reg[MRSA_ZERO_BIT] <= flags_reg.zero_flag;
        rdata_reg[MRSA_RANGE_BIT] <= flags_reg.signed_range_flag;
      end else if (bus_addr == MRSA_PTR_OFFSET) begin
        rdata_reg <= table_pointer_reg;
      end else if (bus_addr == MRSA_HIGH_OFFSET) begin
        rdata_reg <= table_high_latch_reg;
      end else if (bus_addr == MRSA_STATE_OFFSET) begin
        rdata_reg <= 8'h00;
        rdata_reg[MRSA_SKIP_BIT] <= last_skip_reg;
        rdata_reg[MRSA_BUSY_BIT] <= busy_reg;
      end else if (bus_in_mem) begin
        rdata_reg <= dmem[bus_mem_off[MRSA_MEM_AW-1:0]];
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign skip_next = skip_reg;
  assign prog_addr = prog_addr_reg;
  assign prog_rd = prog_rd_reg;
  assign bus_rdata = rdata_reg;

endmodule : mrsa_core

// ---- testbench/mrsa_core_sva.sv ----
// Checker of the command, fetch and register port timing of the datapath.
`timescale 1ns/1ps
module mrsa_core_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire mrsa_pkg::mrsa_cmd_s cmd,
  input wire logic busy,
  input wire logic done,
  input wire logic skip_next,
  input wire logic [mrsa_pkg::MRSA_PROG_AW-1:0] prog_addr,
  input wire logic prog_rd,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  import mrsa_pkg::*;
  logic take;
  mrsa_op_e last_op_reg;

  function automatic logic is_skip(input mrsa_op_e op);
    return op inside {MRSA_SKIP_AFTER_DECREMENT, MRSA_SKIP_AFTER_INCREMENT, MRSA_SKIP_IF_BIT_ONE,
      MRSA_SKIP_IF_BIT_ZERO, MRSA_SKIP_IF_BYTE_ZERO, MRSA_SKIP_IF_ZERO_WITH_LOAD};
  endfunction : is_skip

  function automatic logic is_table(input mrsa_op_e op);
    return op inside {MRSA_TABLE_READ_CURRENT_PAGE, MRSA_TABLE_READ_LAST_PAGE};
  endfunction : is_table

  assign take = cmd_valid && !busy && (cmd.op != MRSA_NOP);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      last_op_reg <= MRSA_NOP;
    end else if (take) begin
      last_op_reg <= cmd.op;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_plain_done_time: assert property (
    take && !is_skip(cmd.op) && !is_table(cmd.op) |=> busy ##1 (done && !busy))
    else $error("plain operation did not finish two cycles after acceptance");
  chk_skip_two_cycles: assert property (
    take && is_skip(cmd.op) |=> busy [*2] ##1 (done && !busy))
    else $error("skip operation did not take its dummy cycle");
  chk_table_fetch: assert property (
    take && is_table(cmd.op) |=> busy ##1 prog_rd ##2 done)
    else $error("table read did not fetch and finish on time");
  chk_current_page: assert property (
    take && cmd.op == MRSA_TABLE_READ_CURRENT_PAGE |-> ##2
    prog_addr[MRSA_PROG_AW-1:MRSA_PTR_W] == $past(cmd.code_page, 2))
    else $error("current page fetch used a wrong page");
  chk_last_page: assert property (
    take && cmd.op == MRSA_TABLE_READ_LAST_PAGE |-> ##2
    prog_addr[MRSA_PROG_AW-1:MRSA_PTR_W] == 5'h1f)
    else $error("last page fetch did not use the final page");
  chk_skip_source: assert property (
    skip_next |-> done && is_skip(last_op_reg))
    else $error("skip signalled outside the end of a skip operation");
  chk_done_pulse: assert property (done |=> !done && !skip_next)
    else $error("done or skip held longer than one cycle");
  chk_fetch_pulse: assert property (prog_rd |=> !prog_rd && busy)
    else $error("program fetch request held longer than one cycle");
  chk_read_slot: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data shown outside its slot");
  chk_idle_done: assert property (done |-> !busy)
    else $error("busy still high while done");
endmodule : mrsa_core_sva

// ---- testbench/test_mrsa_core.sv ----
// Self-checking bench of the rotate, subtract and skip datapath.
`timescale 1ns/1ps
module test_mrsa_core;
  import mrsa_pkg::*;
  localparam logic [9:0] mem_slot = MRSA_DMEM_BASE + 10'h005;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic cmd_valid = 1'h0;
  mrsa_cmd_s cmd = '0;
  logic busy, done, skip_next, prog_rd;
  logic [MRSA_PROG_AW-1:0] prog_addr;
  logic [MRSA_PROG_W-1:0] prog_data = 16'h0000;
  logic [MRSA_BUS_AW-1:0] bus_addr = 10'h000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'h0;
  logic bus_rd = 1'h0;
  logic [7:0] bus_rdata;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  mrsa_cmd_s c;
  logic [7:0] v;
  logic sk;
  logic [15:0] w;

  mrsa_core i_mrsa_core (.clock(clock), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
    .busy(busy), .done(done), .skip_next(skip_next), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

  always #10 clock = ~clock;

  // Program words differ in both bytes for every page; between fetches the bus toggles.
  function automatic logic [15:0] pword(input logic [12:0] a);
    return {a[12:8], a[2:0], a[7:0] ^ {a[12:8], 3'h6}};
  endfunction : pword

  always @(posedge clock) begin
    prog_data <= prog_rd ? pword(prog_addr) : ~prog_data;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic drv(input logic cv, input logic wv, input logic rv);
    cmd_valid <= cv;
    bus_wr <= wv;
    bus_rd <= rv;
  endtask : drv

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    drv(1'h0, 1'h1, 1'h0);
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    drv(1'h0, 1'h0, 1'h1);
    @(posedge clock);
    bus_rd <= 1'h0;
    #1 d = bus_rdata;
  endtask : rd

  task automatic run(input mrsa_cmd_s cc, output logic s);
    int n;
    @(posedge clock);
    cmd <= cc;
    drv(1'h1, 1'h0, 1'h0);
    @(posedge clock);
    cmd_valid <= 1'h0;
    #1 n = 0;
    while (done !== 1'h1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    check("done", {7'h0, done}, 8'h01);
    s = skip_next;
  endtask : run

  // Mode bit 0 selects the accumulator, bit 1 the immediate; ef holds skip above the flags.
  task automatic t(input mrsa_op_e op, input logic [1:0] md, input logic [7:0] x,
    input logic [7:0] a0, input logic [3:0] f0, input logic [7:0] m0,
    input logic [7:0] ea, input logic [4:0] ef, input logic [7:0] em);
    logic [7:0] d;
    logic s;
    wr(MRSA_ACC_OFFSET, a0);
    wr(MRSA_STATUS_OFFSET, {4'h0, f0});
    wr(mem_slot, m0);
    run('{op, md[0], md[1], x, x[2:0], 9'h005, 5'h00}, s);
    rd(MRSA_ACC_OFFSET, d);
    check("acc", d, ea);
    rd(MRSA_STATUS_OFFSET, d);
    check("flags", d, {4'h0, ef[3:0]});
    rd(mem_slot, d);
    check("memory", d, em);
    check("skip", {7'h0, s}, {7'h0, ef[4]});
  endtask : t

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      rd(MRSA_ACC_OFFSET + 10'(4 * k), v);
      check("reset value", v, 8'h00);
    end
    t(MRSA_ROTATE_LEFT_VIA_CARRY, 2'h0, 8'h00, 8'h33, 4'h4, 8'h81, 8'h33, 5'h05, 8'h02);
    t(MRSA_ROTATE_LEFT_VIA_CARRY, 2'h1, 8'h00, 8'h33, 4'h1, 8'h40, 8'h81, 5'h00, 8'h40);
    t(MRSA_ROTATE_RIGHT_IN_PLACE, 2'h0, 8'h00, 8'h00, 4'hf, 8'h01, 8'h00, 5'h0f, 8'h80);
    t(MRSA_ROTATE_RIGHT_IN_PLACE, 2'h1, 8'h00, 8'h00, 4'h0, 8'h02, 8'h01, 5'h00, 8'h02);
    t(MRSA_ROTATE_RIGHT_VIA_CARRY, 2'h0, 8'h00, 8'h00, 4'h0, 8'h01, 8'h00, 5'h01, 8'h00);
    t(MRSA_ROTATE_RIGHT_VIA_CARRY, 2'h1, 8'h00, 8'h00, 4'h1, 8'h02, 8'h81, 5'h00, 8'h02);
    t(MRSA_MINUS_WITH_BORROW, 2'h1, 8'h00, 8'h10, 4'h0, 8'h01, 8'h0e, 5'h01, 8'h01);
    t(MRSA_MINUS_WITH_BORROW, 2'h0, 8'h00, 8'h80, 4'h1, 8'h01, 8'h80, 5'h09, 8'h7f);
    t(MRSA_MINUS, 2'h3, 8'h05, 8'h05, 4'h0, 8'h77, 8'h00, 5'h07, 8'h77);
    t(MRSA_MINUS, 2'h0, 8'h00, 8'h01, 4'h1, 8'h02, 8'h01, 5'h00, 8'hff);
    t(MRSA_SKIP_AFTER_DECREMENT, 2'h0, 8'h00, 8'h00, 4'h0, 8'h01, 8'h00, 5'h10, 8'h00);
    t(MRSA_SKIP_AFTER_DECREMENT, 2'h1, 8'h00, 8'h00, 4'hf, 8'h05, 8'h04, 5'h0f, 8'h05);
    t(MRSA_SKIP_AFTER_INCREMENT, 2'h0, 8'h00, 8'h00, 4'h0, 8'hff, 8'h00, 5'h10, 8'h00);
    t(MRSA_SKIP_AFTER_INCREMENT, 2'h1, 8'h00, 8'h00, 4'h0, 8'h10, 8'h11, 5'h00, 8'h10);
    t(MRSA_SKIP_IF_BIT_ONE, 2'h0, 8'h07, 8'h00, 4'h0, 8'h80, 8'h00, 5'h10, 8'h80);
    t(MRSA_SKIP_IF_BIT_ONE, 2'h0, 8'h00, 8'h00, 4'h0, 8'hfe, 8'h00, 5'h00, 8'hfe);
    t(MRSA_SKIP_IF_BIT_ZERO, 2'h0, 8'h03, 8'h00, 4'h0, 8'hf7, 8'h00, 5'h10, 8'hf7);
    t(MRSA_SKIP_IF_BIT_ZERO, 2'h0, 8'h03, 8'h00, 4'h0, 8'h08, 8'h00, 5'h00, 8'h08);
    t(MRSA_SKIP_IF_BYTE_ZERO, 2'h0, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 5'h10, 8'h00);
    t(MRSA_SKIP_IF_BYTE_ZERO, 2'h0, 8'h00, 8'h00, 4'h0, 8'h01, 8'h00, 5'h00, 8'h01);
    t(MRSA_SKIP_IF_ZERO_WITH_LOAD, 2'h1, 8'h00, 8'h55, 4'h0, 8'h00, 8'h00, 5'h10, 8'h00);
    t(MRSA_SKIP_IF_ZERO_WITH_LOAD, 2'h1, 8'h00, 8'h55, 4'h0, 8'h3c, 8'h3c, 5'h00, 8'h3c);
    t(MRSA_SET_BYTE, 2'h0, 8'h00, 8'h00, 4'h0, 8'h12, 8'h00, 5'h00, 8'hff);
    t(MRSA_SET_BIT, 2'h0, 8'h04, 8'h00, 4'h0, 8'h00, 8'h00, 5'h00, 8'h10);
    t(MRSA_NIBBLE_EXCHANGE, 2'h0, 8'h00, 8'h00, 4'h0, 8'ha5, 8'h00, 5'h00, 8'h5a);
    t(MRSA_NIBBLE_EXCHANGE, 2'h1, 8'h00, 8'h00, 4'h0, 8'h3c, 8'hc3, 5'h00, 8'h3c);
    t(MRSA_EXCLUSIVE_OR, 2'h1, 8'h00, 8'hf0, 4'hf, 8'h0f, 8'hff, 5'h0b, 8'h0f);
    t(MRSA_EXCLUSIVE_OR, 2'h0, 8'h00, 8'h5a, 4'h0, 8'h5a, 8'h5a, 5'h04, 8'h00);
    t(MRSA_EXCLUSIVE_OR, 2'h3, 8'h12, 8'h12, 4'h0, 8'h33, 8'h00, 5'h04, 8'h33);
    for (int i = 0; i < 2; i++) begin
      wr(MRSA_PTR_OFFSET, 8'h21);
      wr(MRSA_HIGH_OFFSET, 8'h77);
      c = '{i ? MRSA_TABLE_READ_LAST_PAGE : MRSA_TABLE_READ_CURRENT_PAGE, 1'h0, 1'h0, 8'h00,
        3'h0, 9'h005, 5'h03};
      w = pword({i ? 5'h1f : 5'h03, 8'h21});
      run(c, sk);
      rd(mem_slot, v);
      check("table low byte", v, w[7:0]);
      rd(MRSA_HIGH_OFFSET, v);
      check("table high byte", v, w[15:8]);
    end
    wr(10'h3ff, 8'haa);
    rd(10'h3ff, v);
    check("unmapped", v, 8'h00);
    give_verdict();
  end
endmodule : test_mrsa_core

bind mrsa_core mrsa_core_sva i_mrsa_core_sva (.clock(clock), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd(cmd), .busy(busy), .done(done), .skip_next(skip_next),
  .prog_addr(prog_addr), .prog_rd(prog_rd), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
